// >>> dv/phy_mgmt_regs_cable_diag_tb_top.sv
/* self-checking bench for the PHY management register bank.
   assumes the bank's AXI4-Lite timing from its hand-over; drives PHY inputs itself. */
`timescale 1ns/1ps
module phy_mgmt_regs_cable_diag_tb_top import pmr_pkg::*;;
    logic core_clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, partnerAbility, advAbility;
    logic [1:0] s_axi_bresp, s_axi_rresp, tdrResult;
    logic polarityReversed, crossoverState, partnerPause, tdrDone, tdrShort, sh;
    logic [8:0] tdrCount, c;
    logic advPause, forceLink, powerSaveDis, nearLoopback, tdrStart, irq;
    logic [15:0] v;
    int failures, checks;

    pmr_mgmt_regs DUT (.core_clk, .rst_b, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .polarityReversed, .crossoverState, .partnerPause, .partnerAbility,
        .tdrDone, .tdrResult, .tdrShort, .tdrCount, .advPause, .advAbility, .forceLink,
        .powerSaveDis, .nearLoopback, .tdrStart, .irq);

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    function automatic logic [31:0] advExp(input logic [15:0] w);
        return {21'h0, w[10], 1'b0, w[8:5], 5'h01};
    endfunction : advExp

    // alias view swaps the start and short-flag positions
    function automatic logic [31:0] diagExp(input logic al, st, input logic [1:0] res,
                                            input logic s, input logic [8:0] n);
        return al ? {16'h0000, s, res, st, 3'h0, n} : {16'h0000, st, res, s, 3'h0, n};
    endfunction : diagExp

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wrChk(input logic [7:0] a, input logic [15:0] w, input logic [1:0] rsp);
        logic bDone;
        bDone = 1'b0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, w};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!bDone) begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                bDone = 1'b1;
                s_axi_bready <= 1'b0;
                chk({30'h0, s_axi_bresp}, {30'h0, rsp});
            end
        end
    endtask : wrChk

    task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] rsp,
                         input logic [31:0] m = 32'hFFFF_FFFF);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata & m, e);
        chk({30'h0, s_axi_rresp}, {30'h0, rsp});
    endtask : rdChk

    task automatic finish_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test

    // whole run is a few hundred cycles; this leaves wide margin
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        finish_test();
    end

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
        {polarityReversed, crossoverState, partnerPause, partnerAbility} = '0;
        {tdrDone, tdrResult, tdrShort, tdrCount} = '0;
        s_axi_wstrb = 4'hF;
        rst_b = 1'b0;
        failures = 0;
        checks = 0;
        void'($urandom(10));
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        chk({22'h0, advPause, advAbility, forceLink, powerSaveDis, nearLoopback, tdrStart, irq},
            32'h0000_03E8);
        rdChk(8'h18, {16'h0000, PHY_ID_HIGH}, RESP_OKAY);
        rdChk(8'h20, 32'h0000_05E1, RESP_OKAY);
        rdChk(8'h28, 32'h0000_0001, RESP_OKAY);
        rdChk(8'h08, 32'h0000_0004, RESP_OKAY);
        rdChk(8'h10, 32'h0000_0000, RESP_OKAY);
        wrChk(8'h18, 16'hFFFF, RESP_OKAY);
        rdChk(8'h18, {16'h0000, PHY_ID_HIGH}, RESP_OKAY);
        wrChk(8'h3C, 16'h1234, RESP_SLVERR);
        rdChk(8'h3C, 32'h0000_0000, RESP_SLVERR);
        $display("test reset_and_map done");
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($urandom);
            polarityReversed <= 1'($urandom);
            crossoverState <= 1'($urandom);
            partnerPause <= 1'($urandom);
            partnerAbility <= 4'($urandom);
            wrChk(8'h20, v, RESP_OKAY);
            rdChk(8'h20, advExp(v), RESP_OKAY);
            chk({27'h0, advPause, advAbility}, {27'h0, v[10], v[8:5]});
            wrChk(8'h08, v, RESP_OKAY);
            rdChk(8'h08, {26'h0, polarityReversed, crossoverState, v[3:1], 1'b0},
                  RESP_OKAY);
            chk({29'h0, forceLink, powerSaveDis, nearLoopback}, {29'h0, v[3:1]});
            rdChk(8'h28, {21'h0, partnerPause, 1'b0, partnerAbility, 5'h01},
                  RESP_OKAY);
        end
        // low lane only: bit 10 and bit 8 must keep their values
        s_axi_wstrb <= 4'h1;
        wrChk(8'h20, 16'h0000, RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rdChk(8'h20, advExp({v[15:8], 8'h00}), RESP_OKAY);
        $display("test random_fields done");
        wrChk(8'h80, 16'h0007, RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            sh = 1'($urandom);
            c = (i == 3) ? 9'h1FF : 9'($urandom);
            // odd passes mask the done event in, even passes keep irq quiet
            wrChk(8'h84, {15'h0000, i[0]}, RESP_OKAY);
            // upper passes start the test through the alias view's start bit
            wrChk(i[1] ? 8'h40 : 8'h10, i[1] ? 16'h1000 : 16'h8000, RESP_OKAY);
            chk({31'h0, tdrStart}, 32'h0000_0001);
            rdChk(8'h10, 32'h0000_8000, RESP_OKAY, 32'h0000_8000);
            @(posedge core_clk);
            tdrDone <= 1'b1;
            tdrResult <= i[1:0];
            tdrShort <= sh;
            tdrCount <= c;
            @(posedge core_clk);
            tdrDone <= 1'b0;
            repeat (3) @(posedge core_clk);
            chk({31'h0, irq}, {31'h0, i[0]});
            rdChk(8'h80, 32'h0000_0001, RESP_OKAY);
            rdChk(8'h84, {31'h0, i[0]}, RESP_OKAY);
            rdChk(8'h10, diagExp(1'b0, 1'b0, i[1:0], sh, c), RESP_OKAY);
            rdChk(8'h40, diagExp(1'b1, 1'b0, i[1:0], sh, c), RESP_OKAY);
            wrChk(8'h80, 16'h0001, RESP_OKAY);
            repeat (2) @(posedge core_clk);
            chk({31'h0, irq}, 32'h0000_0000);
        end
        polarityReversed <= !polarityReversed;
        repeat (2) @(posedge core_clk);
        rdChk(8'h80, 32'h0000_0002, RESP_OKAY, 32'h0000_0002);
        $display("test cable_diag done");
        finish_test();
    end
endmodule : phy_mgmt_regs_cable_diag_tb_top

// >>> logic/pmr_diag_if.sv
/*
 * Link between the register bank and the cable diagnostic sequencer.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/1ps
interface pmr_diag_if;
    import pmr_pkg::*;
    logic startReq;
    logic busy;
    logic [1:0] result;
    logic shortNear;
    logic [CNT_W-1:0] faultCount;
    logic doneEvt;
    logic tdrStart;
    modport ctl (output startReq, input busy, result, shortNear, faultCount, doneEvt, tdrStart);
    modport unit (input startReq, output busy, result, shortNear, faultCount, doneEvt, tdrStart);
endinterface : pmr_diag_if

// >>> logic/pmr_diag_unit.sv
/*
 * Cable diagnostic sequencer: starts the measurement, keeps the start bit up
 * while it runs and latches the outcome when the measurement reports done.
 * Assumes tdrDone is a one-cycle pulse synchronous to core_clk.
 */
`timescale 1ns/1ps
module pmr_diag_unit
    import pmr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    pmr_diag_if.unit dif,
    input wire logic tdrDone,
    input wire logic [1:0] tdrResult,
    input wire logic tdrShort,
    input wire logic [CNT_W-1:0] tdrCount
);
    localparam pmr_diag_st_t ST_RST = '{state: DIAG_IDLE, result: 2'h0, shortNear: 1'b0,
        faultCount: 9'h000, tdrStart: 1'b0, doneEvt: 1'b0};

    pmr_diag_st_t st_ff;
    pmr_diag_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.tdrStart = 1'b0;
        nxt_st.doneEvt = 1'b0;
        case (st_ff.state)
            DIAG_IDLE: begin
                if (dif.startReq) begin
                    nxt_st.state = DIAG_RUN;
                    nxt_st.tdrStart = 1'b1;
                end
            end
            DIAG_RUN: begin
                if (tdrDone) begin
                    // results land on the same edge that drops busy
                    nxt_st.state = DIAG_IDLE;
                    nxt_st.result = tdrResult;
                    nxt_st.shortNear = tdrShort;
                    nxt_st.faultCount = tdrCount;
                    nxt_st.doneEvt = 1'b1;
                end
            end
            default: nxt_st = ST_RST;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign dif.busy = (st_ff.state == DIAG_RUN);
    assign dif.result = st_ff.result;
    assign dif.shortNear = st_ff.shortNear;
    assign dif.faultCount = st_ff.faultCount;
    assign dif.doneEvt = st_ff.doneEvt;
    assign dif.tdrStart = st_ff.tdrStart;

    a_diag_selfclr: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        (st_ff.state == DIAG_RUN) && tdrDone |=> !dif.busy && dif.doneEvt)
        else $error("diag start bit did not clear on done");
    a_diag_latch: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        $fell(dif.busy) |-> dif.result == $past(tdrResult) && dif.faultCount == $past(tdrCount))
        else $error("diag results not valid when start bit fell");
endmodule : pmr_diag_unit

// >>> logic/pmr_mgmt_regs.sv
/*
 * PHY management register bank on an AXI4-Lite slave: port 2 identifier,
 * advertisement and partner ability, port 1 special control/status, port 2
 * cable diagnostic with its alias, and an interrupt status/mask pair.
 * Assumes PHY status inputs are synchronous to core_clk.
 */
`timescale 1ns/1ps
module pmr_mgmt_regs
    import pmr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic polarityReversed,
    input wire logic crossoverState,
    input wire logic partnerPause,
    input wire logic [3:0] partnerAbility,
    input wire logic tdrDone,
    input wire logic [1:0] tdrResult,
    input wire logic tdrShort,
    input wire logic [CNT_W-1:0] tdrCount,
    output logic advPause,
    output logic [3:0] advAbility,
    output logic forceLink,
    output logic powerSaveDis,
    output logic nearLoopback,
    output logic tdrStart,
    output logic irq
);
    localparam pmr_regs_st_t ST_RST = '{
        awready: 1'b1, awGot: 1'b0, awIdx: 6'h00,
        wready: 1'b1, wGot: 1'b0, wData: 16'h0000, wStrb: 2'h0,
        bvalid: 1'b0, bresp: RESP_OKAY,
        arready: 1'b1, rvalid: 1'b0, rdata: 32'h0000_0000, rresp: RESP_OKAY,
        advPause: ADV_PAUSE_RST, advAbility: ADV_ABIL_RST,
        forceLink: FLNK_RST, powerSaveDis: PWR_DIS_RST, nearLoopback: LOOP_RST,
        intStatus: 3'h0, intMask: 3'h0, irq: 1'b0,
        polPrev: 1'b0, partnerPrev: 5'h00
    };

    pmr_regs_st_t st_ff;
    pmr_regs_st_t nxt_st;
    pmr_diag_if dif ();

    logic [REG_W-1:0] advImg;
    logic [REG_W-1:0] partnerImg;
    logic [REG_W-1:0] p1Img;
    logic [REG_W-1:0] diagImg;
    logic [REG_W-1:0] aliasImg;
    logic [REG_W-1:0] intStatusImg;
    logic [REG_W-1:0] intMaskImg;
    logic [REG_W-1:0] wrMask;
    logic [REG_W-1:0] wrBits;
    logic [REG_W-1:0] rdImg;
    logic rdMapped;
    logic wrMapped;
    logic awFire;
    logic wFire;
    logic arFire;
    logic wrFire;
    logic [5:0] arIdx;
    logic [4:0] partnerNow;
    logic [INT_W-1:0] intEvents;
    logic [INT_W-1:0] intClear;
    logic [REG_W-1:0] advMerged;
    logic [REG_W-1:0] p1Merged;

    pmr_diag_unit u_diag (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .dif(dif.unit),
        .tdrDone(tdrDone),
        .tdrResult(tdrResult),
        .tdrShort(tdrShort),
        .tdrCount(tdrCount)
    );

    // register images as software sees them
    always_comb begin
        advImg = 16'h0000;
        advImg[ADV_PAUSE_BIT] = st_ff.advPause;
        advImg[ABIL_HI:ABIL_LO] = st_ff.advAbility;
        advImg[4:0] = SELECTOR_8023;
        partnerImg = 16'h0000;
        partnerImg[ADV_PAUSE_BIT] = partnerPause;
        partnerImg[ABIL_HI:ABIL_LO] = partnerAbility;
        partnerImg[4:0] = PARTNER_LOW_RSV;
        p1Img = 16'h0000;
        p1Img[P1_POL_BIT] = polarityReversed;
        p1Img[P1_XOVER_BIT] = crossoverState;
        p1Img[P1_FLNK_BIT] = st_ff.forceLink;
        p1Img[P1_PWR_BIT] = st_ff.powerSaveDis;
        p1Img[P1_LOOP_BIT] = st_ff.nearLoopback;
        // both views are built from one copy of the diag state
        diagImg = 16'h0000;
        diagImg[DIAG_START_BIT] = dif.busy;
        diagImg[DIAG_RES_LO+1:DIAG_RES_LO] = dif.result;
        diagImg[DIAG_SHORT_BIT] = dif.shortNear;
        diagImg[CNT_W-1:0] = dif.faultCount;
        aliasImg = 16'h0000;
        aliasImg[ALIAS_SHORT_BIT] = dif.shortNear;
        aliasImg[ALIAS_RES_LO+1:ALIAS_RES_LO] = dif.result;
        aliasImg[ALIAS_START_BIT] = dif.busy;
        aliasImg[CNT_W-1:0] = dif.faultCount;
        intStatusImg = {13'h0000, st_ff.intStatus};
        intMaskImg = {13'h0000, st_ff.intMask};
    end

    assign awFire = s_axi_awvalid && st_ff.awready;
    assign wFire = s_axi_wvalid && st_ff.wready;
    assign arFire = s_axi_arvalid && st_ff.arready;
    assign wrFire = st_ff.awGot && st_ff.wGot && !st_ff.bvalid;
    assign arIdx = s_axi_araddr[7:2];
    assign wrMask = {{8{st_ff.wStrb[1]}}, {8{st_ff.wStrb[0]}}};
    assign wrBits = st_ff.wData & wrMask;
    assign advMerged = (advImg & ~wrMask) | wrBits;
    assign p1Merged = (p1Img & ~wrMask) | wrBits;
    assign partnerNow = {partnerPause, partnerAbility};

    // read decode
    always_comb begin
        rdMapped = 1'b1;
        case (arIdx)
            IDX_ID_HIGH: rdImg = PHY_ID_HIGH;
            IDX_ADV: rdImg = advImg;
            IDX_PARTNER: rdImg = partnerImg;
            IDX_P1_CTRL: rdImg = p1Img;
            IDX_DIAG: rdImg = diagImg;
            IDX_DIAG_ALIAS: rdImg = aliasImg;
            IDX_INT_STATUS: rdImg = intStatusImg;
            IDX_INT_MASK: rdImg = intMaskImg;
            default: begin
                rdImg = 16'h0000;
                rdMapped = 1'b0;
            end
        endcase
    end

    always_comb begin
        case (st_ff.awIdx)
            IDX_ID_HIGH, IDX_ADV, IDX_PARTNER, IDX_P1_CTRL, IDX_DIAG,
            IDX_DIAG_ALIAS, IDX_INT_STATUS, IDX_INT_MASK: wrMapped = 1'b1;
            default: wrMapped = 1'b0;
        endcase
    end

    // only the start bit of either diag view launches a test
    always_comb begin
        dif.startReq = 1'b0;
        if (wrFire && !dif.busy) begin
            if (st_ff.awIdx == IDX_DIAG) begin
                dif.startReq = wrBits[DIAG_START_BIT];
            end else if (st_ff.awIdx == IDX_DIAG_ALIAS) begin
                dif.startReq = wrBits[ALIAS_START_BIT];
            end
        end
    end

    always_comb begin
        intEvents = '0;
        intEvents[INT_DIAG_BIT] = dif.doneEvt;
        intEvents[INT_POL_BIT] = polarityReversed != st_ff.polPrev;
        intEvents[INT_PARTNER_BIT] = partnerNow != st_ff.partnerPrev;
        intClear = '0;
        if (wrFire && st_ff.awIdx == IDX_INT_STATUS) begin
            intClear = wrBits[INT_W-1:0];
        end
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.polPrev = polarityReversed;
        nxt_st.partnerPrev = partnerNow;
        // an event in the clearing cycle survives the clear
        nxt_st.intStatus = (st_ff.intStatus & ~intClear) | intEvents;
        if (awFire) begin
            nxt_st.awGot = 1'b1;
            nxt_st.awIdx = s_axi_awaddr[7:2];
            nxt_st.awready = 1'b0;
        end
        if (wFire) begin
            nxt_st.wGot = 1'b1;
            nxt_st.wData = s_axi_wdata[REG_W-1:0];
            nxt_st.wStrb = s_axi_wstrb[1:0];
            nxt_st.wready = 1'b0;
        end
        if (wrFire) begin
            nxt_st.awGot = 1'b0;
            nxt_st.wGot = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = wrMapped ? RESP_OKAY : RESP_SLVERR;
            case (st_ff.awIdx)
                IDX_ADV: begin
                    nxt_st.advPause = advMerged[ADV_PAUSE_BIT];
                    nxt_st.advAbility = advMerged[ABIL_HI:ABIL_LO];
                end
                IDX_P1_CTRL: begin
                    nxt_st.forceLink = p1Merged[P1_FLNK_BIT];
                    nxt_st.powerSaveDis = p1Merged[P1_PWR_BIT];
                    nxt_st.nearLoopback = p1Merged[P1_LOOP_BIT];
                end
                IDX_INT_MASK: begin
                    nxt_st.intMask = (st_ff.intMask & ~wrMask[INT_W-1:0])
                        | wrBits[INT_W-1:0];
                end
                default: begin
                    // read-only and reserved fields drop the write
                    nxt_st.bresp = wrMapped ? RESP_OKAY : RESP_SLVERR;
                end
            endcase
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
            nxt_st.awready = 1'b1;
            nxt_st.wready = 1'b1;
        end
        if (arFire) begin
            nxt_st.arready = 1'b0;
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = {16'h0000, rdImg};
            nxt_st.rresp = rdMapped ? RESP_OKAY : RESP_SLVERR;
        end
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
            nxt_st.arready = 1'b1;
        end
        nxt_st.irq = |(nxt_st.intStatus & nxt_st.intMask);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready = st_ff.wready;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;
    assign advPause = st_ff.advPause;
    assign advAbility = st_ff.advAbility;
    assign forceLink = st_ff.forceLink;
    assign powerSaveDis = st_ff.powerSaveDis;
    assign nearLoopback = st_ff.nearLoopback;
    assign tdrStart = dif.tdrStart;
    assign irq = st_ff.irq;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    a_id_read: assert property (
        arFire && arIdx == IDX_ID_HIGH |=> s_axi_rvalid && s_axi_rdata == {16'h0000, PHY_ID_HIGH})
        else $error("identifier read wrong");
    a_adv_pause: assert property (
        wrFire && st_ff.awIdx == IDX_ADV && st_ff.wStrb[1]
        |=> advPause == $past(st_ff.wData[ADV_PAUSE_BIT]))
        else $error("pause advertise not written");
    a_adv_reset: assert property (
        $rose(rst_b) |-> advPause && advAbility == ADV_ABIL_RST && powerSaveDis)
        else $error("advertise or power saving reset value wrong");
    a_adv_abil: assert property (
        wrFire && st_ff.awIdx == IDX_ADV && (&st_ff.wStrb)
        |=> advAbility == $past(st_ff.wData[ABIL_HI:ABIL_LO]))
        else $error("ability advertise not written");
    a_lp_pause: assert property (
        arFire && arIdx == IDX_PARTNER |=> s_axi_rdata[ADV_PAUSE_BIT] == $past(partnerPause))
        else $error("partner pause read wrong");
    a_lp_abil: assert property (
        arFire && arIdx == IDX_PARTNER
        |=> s_axi_rdata[ABIL_HI:ABIL_LO] == $past(partnerAbility))
        else $error("partner ability read wrong");
    a_pol_read: assert property (
        arFire && arIdx == IDX_P1_CTRL |=> s_axi_rdata[P1_POL_BIT] == $past(polarityReversed))
        else $error("polarity read wrong");
    a_force_link: assert property (
        wrFire && st_ff.awIdx == IDX_P1_CTRL && st_ff.wStrb[0]
        |=> forceLink == $past(st_ff.wData[P1_FLNK_BIT])
            && powerSaveDis == $past(st_ff.wData[P1_PWR_BIT]))
        else $error("force link or power saving not written");
    a_near_loop: assert property (
        wrFire && st_ff.awIdx == IDX_P1_CTRL && st_ff.wStrb[0]
        |=> nearLoopback == $past(st_ff.wData[P1_LOOP_BIT]))
        else $error("loopback not written");
    a_diag_start: assert property (
        dif.startReq |=> dif.busy && tdrStart ##1 !tdrStart)
        else $error("diag did not start");
    a_diag_outcome: assert property (
        arFire && arIdx == IDX_DIAG
        |=> s_axi_rdata[DIAG_RES_LO+1:DIAG_RES_LO] == $past(dif.result))
        else $error("diag outcome read wrong");
    a_short_read: assert property (
        arFire && arIdx == IDX_DIAG |=> s_axi_rdata[DIAG_SHORT_BIT] == $past(dif.shortNear))
        else $error("short flag read wrong");
    a_count_read: assert property (
        arFire && arIdx == IDX_DIAG |=> s_axi_rdata[CNT_W-1:0] == $past(dif.faultCount)
            && s_axi_rdata[11:9] == 3'h0)
        else $error("fault count read wrong");
    a_alias_same: assert property (
        arFire && arIdx == IDX_DIAG_ALIAS |=> s_axi_rdata[ALIAS_START_BIT] == $past(dif.busy)
            && s_axi_rdata[ALIAS_SHORT_BIT] == $past(dif.shortNear))
        else $error("alias view differs");
    a_resv_zero: assert property (
        arFire && arIdx == IDX_P1_CTRL |=> s_axi_rdata[31:6] == 26'h000_0000
            && s_axi_rdata[0] == 1'b0)
        else $error("reserved bits not zero");
    a_sel_field: assert property (
        arFire && arIdx == IDX_ADV |=> s_axi_rdata[4:0] == SELECTOR_8023)
        else $error("selector field wrong");
endmodule : pmr_mgmt_regs

// >>> logic/pmr_pkg.sv
/*
 * Shared constants and types of the PHY management register bank:
 * register indices, field positions, reset values, bus answers and state.
 * Assumes a 32-bit AXI4-Lite bus with 8 address bits; byte address = 4 x index.
 */
package pmr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_P1_CTRL = 6'h02;
    localparam logic [5:0] IDX_DIAG = 6'h04;
    localparam logic [5:0] IDX_ID_HIGH = 6'h06;
    localparam logic [5:0] IDX_ADV = 6'h08;
    localparam logic [5:0] IDX_PARTNER = 6'h0A;
    localparam logic [5:0] IDX_DIAG_ALIAS = 6'h10;
    localparam logic [5:0] IDX_INT_STATUS = 6'h20;
    localparam logic [5:0] IDX_INT_MASK = 6'h21;

    // arbitrary value, not a real vendor code
    localparam logic [15:0] PHY_ID_HIGH = 16'h5A5A;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int ADV_PAUSE_BIT = 10;
    localparam int ABIL_HI = 8;
    localparam int ABIL_LO = 5;
    localparam logic [4:0] SELECTOR_8023 = 5'h01;
    localparam logic [4:0] PARTNER_LOW_RSV = 5'h01;

    localparam int P1_POL_BIT = 5;
    localparam int P1_XOVER_BIT = 4;
    localparam int P1_FLNK_BIT = 3;
    localparam int P1_PWR_BIT = 2;
    localparam int P1_LOOP_BIT = 1;

    localparam int DIAG_START_BIT = 15;
    localparam int DIAG_RES_LO = 13;
    localparam int DIAG_SHORT_BIT = 12;
    localparam int ALIAS_SHORT_BIT = 15;
    localparam int ALIAS_RES_LO = 13;
    localparam int ALIAS_START_BIT = 12;
    localparam int CNT_W = 9;

    localparam int INT_W = 3;
    localparam int INT_DIAG_BIT = 0;
    localparam int INT_POL_BIT = 1;
    localparam int INT_PARTNER_BIT = 2;

    localparam logic ADV_PAUSE_RST = 1'b1;
    localparam logic [3:0] ADV_ABIL_RST = 4'hF;
    localparam logic FLNK_RST = 1'b0;
    localparam logic PWR_DIS_RST = 1'b1;
    localparam logic LOOP_RST = 1'b0;

    typedef enum logic {DIAG_IDLE = 1'b0, DIAG_RUN = 1'b1} pmr_diag_state_t;

    typedef struct packed {
        pmr_diag_state_t state;
        logic [1:0] result;
        logic shortNear;
        logic [CNT_W-1:0] faultCount;
        logic tdrStart;
        logic doneEvt;
    } pmr_diag_st_t;

    typedef struct packed {
        logic awready;
        logic awGot;
        logic [5:0] awIdx;
        logic wready;
        logic wGot;
        logic [REG_W-1:0] wData;
        logic [1:0] wStrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
        logic advPause;
        logic [3:0] advAbility;
        logic forceLink;
        logic powerSaveDis;
        logic nearLoopback;
        logic [INT_W-1:0] intStatus;
        logic [INT_W-1:0] intMask;
        logic irq;
        logic polPrev;
        logic [4:0] partnerPrev;
    } pmr_regs_st_t;
endpackage : pmr_pkg
